// ### hdl/mdrcp_regs.vh
// mdrcp_regs.vh: offsets, field positions, reset values, character codes
// assumes: included by the parser top; definitions only
`ifndef MDRCP_REGS_VH
`define MDRCP_REGS_VH
// ==========================================================
// register byte offsets
`define MDRCP_CFG_OFS     8'h00
`define MDRCP_STAT_OFS    8'h04
`define MDRCP_UNIT_OFS    8'h08
// ==========================================================
// configuration field positions
`define MDRCP_CL_LSB      0
`define MDRCP_LOCK_LSB    3
`define MDRCP_MT_LSB      6
`define MDRCP_BEEP_BIT    8
`define MDRCP_DCHK_BIT    9
`define MDRCP_ANT_BIT     10
`define MDRCP_CR_BIT      11
`define MDRCP_LF_BIT      12
`define MDRCP_BCC_BIT     13
`define MDRCP_TRIG_BIT    14
`define MDRCP_CFG_RST     15'h5A02
`define MDRCP_UNIT_RST    8'h31
// code length selector meaning a thirteen-character code
`define MDRCP_CL_X        3'h5
// ==========================================================
// character codes
`define MDRCP_CH_CR       8'h0D
`define MDRCP_CH_LF       8'h0A
`define MDRCP_CH_DOT      8'h2E
`define MDRCP_CH_SLASH    8'h2F
`define MDRCP_CH_ZERO     8'h30
`define MDRCP_CH_ONE      8'h31
`define MDRCP_CH_TWO      8'h32
`define MDRCP_CH_HASH     8'h23
`define MDRCP_CH_QUEST    8'h3F
`define MDRCP_CH_X        8'h78
`define MDRCP_CH_I        8'h69
`define MDRCP_CH_A        8'h61
`define MDRCP_CH_R        8'h72
`define MDRCP_CH_S        8'h73
`define MDRCP_CH_V        8'h76
`define MDRCP_CH_Z        8'h7A
`define MDRCP_CH_UC_A     8'h41
`define MDRCP_CH_UC_Z     8'h5A
// ==========================================================
// reply kinds
`define MDRCP_RP_VER      3'h0
`define MDRCP_RP_ZAP      3'h1
`define MDRCP_RP_UNIT     3'h2
`define MDRCP_RP_TAG      3'h3
`define MDRCP_RP_ST1      3'h4
`define MDRCP_RP_ST2      3'h5
`define MDRCP_RP_UNK      3'h6
`endif

// ### hdl/mdrcp_parser.v
// mdrcp_parser.v: ascii command interpreter for a multidrop tag reader
// assumes: a uart on clk delivers rx bytes and drains tx bytes;
// a tag front end runs the readings; software sits on apb
//
// Behaviour
// - version query answers a 16-character string then CR LF
// - continuous configuration status word: nine digits in fixed order
// - triggered configuration status word: seven digits in fixed order
// - period starts a normal command, slash starts a protocol command
// - any slash latches protocol mode until the exit command
// - protocol commands are lower case and end with CR
// - each protocol command except the exit carries a unit address; character 0 matches all units
// - identification command replies with the stored unit number
// - set-number command stores the byte following the hash
// - antenna command value 0 or 1 selects that antenna
// - start-read command begins a reading cycle
// - stop command ends a reading and reports; also polls triggered reads
// - good result: unit, tag code characters, CR LF
// - failed reading: unit, digit 1, CR LF
// - no start ever received: unit, digit 2, CR LF
// - addressed unknown command: unit then question mark
// - slash-period releases protocol mode back to normal handling
// - trigger-started read result is only given on a scan command
// - status code-length digit is length minus eight, x for thirteen
`timescale 1ns/100ps
`include "mdrcp_regs.vh"

module mdrcp_parser
#(
    parameter [127:0] FW_VERSION = "CMD-PARSER-V0001" // arbitrary text
)
(
    // clock and reset
    input  wire         clk,
    input  wire         rst_n,
    // apb slave
    input  wire         psel,
    input  wire         penable,
    input  wire         pwrite,
    input  wire [7:0]   paddr,
    input  wire [31:0]  pwdata,
    output reg  [31:0]  prdata,
    output wire         pready,
    output reg          pslverr,
    // serial byte stream
    input  wire         rx_valid,
    input  wire [7:0]   rx_data,
    output reg          tx_valid,
    output reg  [7:0]   tx_data,
    input  wire         tx_ready,
    // tag front end
    input  wire         trigger_pin,
    output reg          read_begin,
    output reg          read_halt,
    input  wire         read_done,
    input  wire         read_found,
    input  wire [103:0] tag_code,
    output wire         antenna_sel,
    output wire [2:0]   lock_code,
    output wire [1:0]   multi_tag,
    output wire         beeper_en,
    output wire         double_check
);

// ==========================================================
// parser states
localparam [3:0] S_IDLE  = 4'b0001;
localparam [3:0] S_NCMD  = 4'b0010;
localparam [3:0] S_PWAIT = 4'b0100;
localparam [3:0] S_PCMD  = 4'b1000;
// reading states
localparam [3:0] R_NEVER = 4'b0001;
localparam [3:0] R_BUSY  = 4'b0010;
localparam [3:0] R_OK    = 4'b0100;
localparam [3:0] R_FAIL  = 4'b1000;

reg  [3:0]  state;
reg  [3:0]  rd_state;
reg  [14:0] cfg;
reg  [7:0]  unit;
reg  [7:0]  b0;
reg  [7:0]  b1;
reg  [7:0]  b2;
reg  [2:0]  cnt;
reg         bad_case;
reg         pend;
reg         tx_busy;
reg  [2:0]  tx_type;
reg  [4:0]  idx;
reg         trig_s1;
reg         trig_s2;
reg         trig_s3;
reg         trig_lvl;

// ==========================================================
// configuration fields
wire [2:0] cl_sel   = cfg[`MDRCP_CL_LSB +: 3];
wire       trig_cfg = cfg[`MDRCP_TRIG_BIT];
assign antenna_sel  = cfg[`MDRCP_ANT_BIT];
assign lock_code    = cfg[`MDRCP_LOCK_LSB +: 3];
assign multi_tag    = cfg[`MDRCP_MT_LSB +: 2];
assign beeper_en    = cfg[`MDRCP_BEEP_BIT];
assign double_check = cfg[`MDRCP_DCHK_BIT];

// code length in characters, x selects thirteen
wire [3:0] code_n = (cl_sel == `MDRCP_CL_X) ? 4'hD
                  : 4'h8 + {1'b0, cl_sel};

// ==========================================================
// trigger pin: three stages, a change counts when stages 2 and 3 agree
always @(posedge clk)
begin
    if (!rst_n)
    begin
        trig_s1  <= 1'b0;
        trig_s2  <= 1'b0;
        trig_s3  <= 1'b0;
        trig_lvl <= 1'b0;
    end
    else
    begin
        trig_s1 <= trigger_pin;
        trig_s2 <= trig_s1;
        trig_s3 <= trig_s2;
        if (trig_s2 == trig_s3)
            trig_lvl <= trig_s3;
    end
end

wire trig_rise = (trig_s2 == trig_s3) && trig_s3 && !trig_lvl;

// ==========================================================
// command decode, evaluated on the terminating CR
wire is_cr   = rx_valid && (rx_data == `MDRCP_CH_CR);
wire ev_norm = is_cr && (state == S_NCMD);
wire ev_prot = is_cr && (state == S_PCMD);
wire is_exit = (cnt == 3'd1) && (b0 == `MDRCP_CH_DOT);
wire addr_ok = (cnt != 3'd0) && ((b0 == unit) || (b0 == `MDRCP_CH_ZERO));
wire ev_go   = ev_prot && !is_exit && addr_ok;
wire c_id    = (cnt == 3'd2) && (b1 == `MDRCP_CH_I);
wire c_num   = (cnt == 3'd3) && (b1 == `MDRCP_CH_HASH);
wire c_ant   = (cnt == 3'd3) && (b1 == `MDRCP_CH_A)
             && ((b2 == `MDRCP_CH_ZERO) || (b2 == `MDRCP_CH_ONE));
wire c_rd    = (cnt == 3'd2) && (b1 == `MDRCP_CH_R);
wire c_stop  = (cnt == 3'd2) && (b1 == `MDRCP_CH_S);
wire c_known = !bad_case && (c_id || c_num || c_ant || c_rd || c_stop);
wire do_id   = ev_go && c_known && c_id;
wire do_num  = ev_go && c_known && c_num;
wire do_ant  = ev_go && c_known && c_ant;
wire do_rd   = ev_go && c_known && c_rd;
wire do_stop = ev_go && c_known && c_stop;
wire do_unk  = ev_go && !c_known;
wire do_ver  = ev_norm && (cnt == 3'd1) && (b0 == `MDRCP_CH_V);
wire do_zap  = ev_norm && (cnt == 3'd1) && (b0 == `MDRCP_CH_Z);

// a byte is upper case, which protocol command characters must not be
wire rx_upper = (rx_data >= `MDRCP_CH_UC_A) && (rx_data <= `MDRCP_CH_UC_Z);

// ==========================================================
// parser state machine and command buffer
always @(posedge clk)
begin
    if (!rst_n)
    begin
        state    <= S_IDLE;
        b0       <= 8'h00;
        b1       <= 8'h00;
        b2       <= 8'h00;
        cnt      <= 3'd0;
        bad_case <= 1'b0;
    end
    else if (rx_valid)
    begin
        if (rx_data == `MDRCP_CH_SLASH)
        begin
            state    <= S_PCMD;
            cnt      <= 3'd0;
            bad_case <= 1'b0;
        end
        else if (is_cr)
        begin
            case (state)
                S_NCMD:  state <= S_IDLE;
                S_PCMD:  state <= is_exit ? S_IDLE : S_PWAIT;
                S_PWAIT: state <= S_PWAIT;
                default: state <= S_IDLE;
            endcase
        end
        else
        begin
            case (state)
                S_IDLE:
                begin
                    if (rx_data == `MDRCP_CH_DOT)
                    begin
                        state <= S_NCMD;
                        cnt   <= 3'd0;
                    end
                end
                S_NCMD, S_PCMD:
                begin
                    // extra characters saturate the count, so the command
                    // is seen as unknown rather than mistaken for a short one
                    if (cnt == 3'd0)
                        b0 <= rx_data;
                    if (cnt == 3'd1)
                        b1 <= rx_data;
                    if (cnt == 3'd2)
                        b2 <= rx_data;
                    if (cnt != 3'd4)
                        cnt <= cnt + 3'd1;
                    if ((cnt != 3'd0) && rx_upper)
                        bad_case <= 1'b1;
                end
                S_PWAIT: state <= S_PWAIT;
                default: state <= S_IDLE;
            endcase
        end
    end
end

// ==========================================================
// configuration and unit number: apb and protocol commands write here
wire apb_wr = psel && penable && pwrite;

always @(posedge clk)
begin
    if (!rst_n)
    begin
        cfg  <= `MDRCP_CFG_RST;
        unit <= `MDRCP_UNIT_RST;
    end
    else
    begin
        if (apb_wr && (paddr == `MDRCP_CFG_OFS))
            cfg <= pwdata[14:0];
        if (apb_wr && (paddr == `MDRCP_UNIT_OFS))
            unit <= pwdata[7:0];
        // the command wins over a same-cycle apb write
        if (do_ant)
            cfg[`MDRCP_ANT_BIT] <= b2[0];
        if (do_num)
            unit <= b2;
    end
end

// ==========================================================
// reading control; the result waits for a stop or scan to fetch it
wire start_req = do_rd || trig_rise;
wire done_now  = (rd_state == R_BUSY) && read_done;

always @(posedge clk)
begin
    if (!rst_n)
    begin
        rd_state   <= R_NEVER;
        pend       <= 1'b0;
        read_begin <= 1'b0;
        read_halt  <= 1'b0;
    end
    else
    begin
        read_begin <= 1'b0;
        read_halt  <= 1'b0;
        case (rd_state)
            R_BUSY:
            begin
                if (read_done)
                begin
                    rd_state <= read_found ? R_OK : R_FAIL;
                    pend     <= 1'b0;
                end
                else if (do_stop)
                begin
                    read_halt <= 1'b1;
                    pend      <= 1'b1;
                end
            end
            R_NEVER, R_OK, R_FAIL:
            begin
                if (start_req && !do_stop)
                begin
                    rd_state   <= R_BUSY;
                    read_begin <= 1'b1;
                end
            end
            default: rd_state <= R_NEVER;
        endcase
    end
end

// ==========================================================
// reply selection; a finished pending stop takes priority
reg       launch;
reg [2:0] next_type;

always @*
begin
    launch    = 1'b0;
    next_type = `MDRCP_RP_UNK;
    if (done_now && (pend || do_stop))
    begin
        launch    = 1'b1;
        next_type = read_found ? `MDRCP_RP_TAG : `MDRCP_RP_ST1;
    end
    else if (do_stop && (rd_state != R_BUSY))
    begin
        launch = 1'b1;
        if (rd_state == R_OK)
            next_type = `MDRCP_RP_TAG;
        else if (rd_state == R_FAIL)
            next_type = `MDRCP_RP_ST1;
        else
            next_type = `MDRCP_RP_ST2;
    end
    else if (do_id)
    begin
        launch    = 1'b1;
        next_type = `MDRCP_RP_UNIT;
    end
    else if (do_unk)
    begin
        launch    = 1'b1;
        next_type = `MDRCP_RP_UNK;
    end
    else if (do_ver)
    begin
        launch    = 1'b1;
        next_type = `MDRCP_RP_VER;
    end
    else if (do_zap)
    begin
        launch    = 1'b1;
        next_type = `MDRCP_RP_ZAP;
    end
end

// ==========================================================
// reply length including the closing CR LF
reg [4:0] tx_len;

always @*
begin
    case (tx_type)
        `MDRCP_RP_VER:  tx_len = 5'd18;
        `MDRCP_RP_ZAP:  tx_len = trig_cfg ? 5'd9 : 5'd11;
        `MDRCP_RP_UNIT: tx_len = 5'd3;
        `MDRCP_RP_TAG:  tx_len = {1'b0, code_n} + 5'd3;
        default:        tx_len = 5'd4;
    endcase
end

// ==========================================================
// character at position idx of the reply
wire [127:0] ver_sh = FW_VERSION << {idx[3:0], 3'b000};
wire [4:0]   tag_of = 5'd12 - {1'b0, code_n} + idx;
wire [103:0] tag_sh = tag_code << {tag_of, 3'b000};
wire [7:0]   cl_dig = (cl_sel == `MDRCP_CL_X) ? `MDRCP_CH_X
                    : `MDRCP_CH_ZERO | {5'h00, cl_sel};
reg  [7:0]   body;
reg  [7:0]   next_ch;

// status digits as ascii, one field per position
function [7:0] dig;
    input [2:0] v;
    begin
        dig = `MDRCP_CH_ZERO | {5'h00, v};
    end
endfunction

always @*
begin
    body = unit;
    case (tx_type)
        `MDRCP_RP_VER: body = ver_sh[127:120];
        `MDRCP_RP_ZAP:
        begin
            if (trig_cfg)
            begin
                case (idx)
                    5'd0:    body = cl_dig;
                    5'd1:    body = dig({1'b0, cfg[7:6]});
                    5'd2:    body = dig({2'b00, cfg[9]});
                    5'd3:    body = dig({2'b00, cfg[10]});
                    5'd4:    body = dig({2'b00, cfg[11]});
                    5'd5:    body = dig({2'b00, cfg[12]});
                    default: body = dig({2'b00, cfg[13]});
                endcase
            end
            else
            begin
                case (idx)
                    5'd0:    body = cl_dig;
                    5'd1:    body = dig(cfg[5:3]);
                    5'd2:    body = dig({1'b0, cfg[7:6]});
                    5'd3:    body = dig({2'b00, cfg[8]});
                    5'd4:    body = dig({2'b00, cfg[9]});
                    5'd5:    body = dig({2'b00, cfg[10]});
                    5'd6:    body = dig({2'b00, cfg[11]});
                    5'd7:    body = dig({2'b00, cfg[12]});
                    default: body = dig({2'b00, cfg[13]});
                endcase
            end
        end
        `MDRCP_RP_TAG:
        begin
            if (idx != 5'd0)
                body = tag_sh[103:96];
        end
        `MDRCP_RP_ST1:
        begin
            if (idx != 5'd0)
                body = `MDRCP_CH_ONE;
        end
        `MDRCP_RP_ST2:
        begin
            if (idx != 5'd0)
                body = `MDRCP_CH_TWO;
        end
        `MDRCP_RP_UNK:
        begin
            if (idx != 5'd0)
                body = `MDRCP_CH_QUEST;
        end
        default: body = unit;
    endcase
    if (idx == tx_len - 5'd2)
        next_ch = `MDRCP_CH_CR;
    else if (idx == tx_len - 5'd1)
        next_ch = `MDRCP_CH_LF;
    else
        next_ch = body;
end

// ==========================================================
// transmit sequencer: one byte per handshake; a command that ends
// while a reply is still going out gets no reply of its own
always @(posedge clk)
begin
    if (!rst_n)
    begin
        tx_busy  <= 1'b0;
        tx_type  <= `MDRCP_RP_UNK;
        idx      <= 5'd0;
        tx_valid <= 1'b0;
        tx_data  <= 8'h00;
    end
    else
    begin
        if (tx_valid && tx_ready)
            tx_valid <= 1'b0;
        if (!tx_busy)
        begin
            if (launch)
            begin
                tx_busy <= 1'b1;
                tx_type <= next_type;
                idx     <= 5'd0;
            end
        end
        else if (!tx_valid || tx_ready)
        begin
            if (idx == tx_len)
                tx_busy <= 1'b0;
            else
            begin
                tx_data  <= next_ch;
                tx_valid <= 1'b1;
                idx      <= idx + 5'd1;
            end
        end
    end
end

// ==========================================================
// apb slave: zero wait states, read data captured in the setup cycle
wire map_ok = (paddr == `MDRCP_CFG_OFS) || (paddr == `MDRCP_STAT_OFS)
            || (paddr == `MDRCP_UNIT_OFS);

assign pready = 1'b1;

always @(posedge clk)
begin
    if (!rst_n)
    begin
        prdata  <= 32'h0000_0000;
        pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
        pslverr <= !map_ok;
        case (paddr)
            `MDRCP_CFG_OFS:  prdata <= {17'h00000, cfg};
            `MDRCP_STAT_OFS: prdata <= {16'h0000, unit, 1'b0, tx_busy,
                                        pend, rd_state, state[3] | state[2]};
            `MDRCP_UNIT_OFS: prdata <= {24'h000000, unit};
            default:         prdata <= 32'h0000_0000;
        endcase
    end
end

endmodule

// ### tb/mdrcp_parser_checker.sv
// mdrcp_parser_checker.sv: port level assertions for the command parser
// assumes: bound to mdrcp_parser; one clock, synchronous active low reset
`timescale 1ns/100ps
`include "mdrcp_regs.vh"
// ==========================================================
// checker
module mdrcp_parser_checker
(
    // clock and reset
    input logic       clk,
    input logic       rst_n,
    // apb
    input logic       psel,
    input logic       penable,
    input logic       pwrite,
    // serial
    input logic       rx_valid,
    input logic       tx_valid,
    input logic [7:0] tx_data,
    input logic       tx_ready,
    // front end
    input logic       trigger_pin,
    input logic       read_begin,
    input logic       read_halt,
    input logic       antenna_sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // config write at the access edge
    wire apb_wr = psel && penable && pwrite;

    chk_begin_pulse: assert property (read_begin |=> !read_begin)
        else $error("read start wider than one cycle");
    chk_begin_cause: assert property (read_begin |-> $past(rx_valid) || $past(trigger_pin))
        else $error("read start without command or trigger");
    chk_halt_pulse: assert property (read_halt |=> !read_halt)
        else $error("read halt wider than one cycle");
    chk_halt_cause: assert property (read_halt |-> $past(rx_valid))
        else $error("read halt without stop command");
    chk_no_overlap: assert property (!(read_begin && read_halt))
        else $error("start and halt together");
    chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("tx byte dropped while stalled");
    chk_crlf_pair: assert property (tx_valid && tx_ready && tx_data == `MDRCP_CH_CR
        |=> tx_valid && tx_data == `MDRCP_CH_LF)
        else $error("carriage return not followed by line feed");
    // antenna may only move after a command byte or a config write
    chk_ant_cause: assert property ($changed(antenna_sel) |-> $past(rx_valid)
        || $past(rx_valid, 2) || $past(apb_wr) || $past(apb_wr, 2))
        else $error("antenna changed without cause");

    cov_begin: cover property (read_begin);
    cov_halt: cover property (read_halt);
    cov_stall: cover property (tx_valid && !tx_ready);
endmodule

bind mdrcp_parser mdrcp_parser_checker u_chk
(
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .rx_valid(rx_valid), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .trigger_pin(trigger_pin), .read_begin(read_begin), .read_halt(read_halt),
    .antenna_sel(antenna_sel)
);

// ### tb/mdrcp_host_model.sv
// mdrcp_host_model.sv: host master on a point to point serial byte link
// assumes: byte stream on the parser clock; the bench reads got directly
`timescale 1ns/100ps
`include "mdrcp_regs.vh"
// ==========================================================
// host model
module mdrcp_host_model
(
    // clock and reset
    input  logic       clk,
    input  logic       rst_n,
    // serial link
    output logic       rx_valid,
    output logic [7:0] rx_data,
    input  logic       tx_valid,
    input  logic [7:0] tx_data,
    output logic       tx_ready
);
    logic [7:0] got[$];
    logic       slow;

    initial
    begin
        rx_valid = 1'h0;
        rx_data  = 8'hA5;
        tx_ready = 1'h1;
        slow     = 1'h0;
    end

    // collect reply bytes; slow mode accepts only every other cycle
    always @(posedge clk)
    begin
        if (tx_valid === 1'h1 && tx_ready === 1'h1)
            got.push_back(tx_data);
        tx_ready <= slow ? ~tx_ready : 1'h1;
    end

    // one command back to back, closed by carriage return
    task send(input string s);
        for (int i = 0; i <= s.len(); i++)
        begin
            rx_valid <= 1'h1;
            rx_data  <= (i == s.len()) ? `MDRCP_CH_CR : s[i];
            @(posedge clk);
        end
        rx_valid <= 1'h0;
        rx_data  <= ~rx_data; // stale byte must not look valid
        @(posedge clk);
    endtask
endmodule

// ### tb/mdrcp_parser_tb.sv
// mdrcp_parser_tb.sv: self checking bench for the command parser
// assumes: host model on the serial link, bench drives apb and front end
`timescale 1ns/100ps
`include "mdrcp_regs.vh"
// ==========================================================
// bench top
module mdrcp_parser_tb;
    logic         clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic         rx_valid, tx_valid, tx_ready, trigger_pin;
    logic         read_begin, read_halt, read_done, read_found;
    logic         antenna_sel, beeper_en, double_check, e;
    logic [7:0]   paddr, rx_data, tx_data;
    logic [31:0]  pwdata, prdata, r;
    logic [103:0] tag_code;
    logic [2:0]   lock_code;
    logic [1:0]   multi_tag;
    int           error_cnt;
    int           n_compared;
    int           n_begin, n_halt;

    mdrcp_parser #(.FW_VERSION("TESTVERSION-0042")) dut
    (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
        .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .trigger_pin(trigger_pin),
        .read_begin(read_begin), .read_halt(read_halt),
        .read_done(read_done), .read_found(read_found),
        .tag_code(tag_code), .antenna_sel(antenna_sel),
        .lock_code(lock_code), .multi_tag(multi_tag),
        .beeper_en(beeper_en), .double_check(double_check)
    );

    mdrcp_host_model host
    (
        .clk(clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready)
    );

    // ==========================================================
    // clock and front end pulse counters
    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (read_begin === 1'h1)
            n_begin <= n_begin + 1;
        if (read_halt === 1'h1)
            n_halt <= n_halt + 1;
    end

    // ==========================================================
    // compares and bus tasks
    task cmp_byte(input logic [7:0] g, input logic [7:0] e);
        cmp_word({24'h0, g}, {24'h0, e});
    endtask

    task cmp_word(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t word %h expected %h", $time, g, e);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'h1;
        do
            @(posedge clk);
        while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask

    // reply text plus carriage return and line feed, nothing more
    task expect_reply(input string s);
        for (int i = 0; i < 300 && host.got.size() < s.len() + 2; i++)
            @(posedge clk);
        repeat (8) @(posedge clk);
        cmp_word(host.got.size(), s.len() + 2);
        for (int i = 0; i < s.len(); i++)
            cmp_byte(host.got[i], s[i]);
        cmp_byte(host.got[s.len()], `MDRCP_CH_CR);
        cmp_byte(host.got[s.len() + 1], `MDRCP_CH_LF);
        host.got.delete();
    endtask

    task expect_none;
        repeat (40) @(posedge clk);
        cmp_word(host.got.size(), 32'h0);
        host.got.delete();
    endtask

    // wait for the expected start and halt counts, then finish the reading
    task fe_done(input logic f, input int nb, input int nh);
        for (int i = 0; i < 100 && (n_begin != nb || n_halt != nh); i++)
            @(posedge clk);
        cmp_word(n_begin, nb);
        cmp_word(n_halt, nh);
        read_done  <= 1'h1;
        read_found <= f;
        @(posedge clk);
        read_done  <= 1'h0;
        @(posedge clk);
    endtask

    // ==========================================================
    // scenarios
    task t_status;
        host.send(".v");
        expect_reply("TESTVERSION-0042");
        host.send(".z");
        expect_reply("2010110");
        apb(1'h1, 8'h00, 32'h0000355D, r, e);
        apb(1'h0, 8'h00, 32'h00000000, r, e);
        cmp_word(r, 32'h0000355D);
        cmp_word({antenna_sel, lock_code, multi_tag, beeper_en, double_check}, 8'hB6);
        host.send(".z");
        expect_reply("x31101011");
        apb(1'h0, 8'h0C, 32'h00000000, r, e);
        cmp_word({r[31:1], r[0] | e}, 32'h00000001);
        apb(1'h1, 8'h00, 32'h00005A02, r, e);
        $display("test status done");
    endtask

    task t_proto;
        host.send("/0i");
        expect_reply("1");
        apb(1'h0, 8'h04, 32'h00000000, r, e);
        cmp_word(r[0], 32'h1);
        host.send(".v");
        expect_none;
        host.send("/2i");
        expect_none;
        host.send("/0#4");
        expect_none;
        host.send("/4i");
        expect_reply("4");
        host.send("/0q");
        expect_reply("4?");
        host.send("/4I");
        expect_reply("4?");
        host.send("/4a1");
        expect_none;
        cmp_word(antenna_sel, 32'h1);
        host.send("/0a0");
        expect_none;
        cmp_word(antenna_sel, 32'h0);
        $display("test protocol done");
    endtask

    task t_read;
        host.send("/4s");
        expect_reply("42");
        host.send("/4r");
        fe_done(1'h0, 1, 0);
        host.send("/4s");
        expect_reply("41");
        host.send("/4r");
        fe_done(1'h1, 2, 0);
        host.send("/4s");
        expect_reply("4D002345A78");
        host.send("/4r");
        host.send("/4s");
        fe_done(1'h0, 3, 1);
        expect_reply("41");
        trigger_pin <= 1'h1;
        repeat (8) @(posedge clk);
        trigger_pin <= 1'h0;
        fe_done(1'h1, 4, 1);
        expect_none;
        host.send("/4s");
        expect_reply("4D002345A78");
        $display("test read done");
    endtask

    task t_exit;
        host.send("/.");
        expect_none;
        apb(1'h0, 8'h04, 32'h00000000, r, e);
        cmp_word(r[0], 32'h0);
        host.slow <= 1'h1;
        host.send(".z");
        expect_reply("2010110");
        host.slow <= 1'h0;
        $display("test exit done");
    endtask

    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial
    begin
        {rst_n, psel, penable, pwrite, trigger_pin, read_done, read_found} = 7'h00;
        {paddr, pwdata} = 40'h0;
        tag_code = "000D002345A78";
        {error_cnt, n_compared, n_begin, n_halt} = 128'h0;
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        t_status;
        t_proto;
        t_read;
        t_exit;
        end_of_test;
    end

    initial
    begin
        #400000;
        error_cnt++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        end_of_test;
    end
endmodule
